// file: cbag_assertions.sv
// port checks for the circular/duplicate-load address generator
`timescale 1ns/1ps
module cbag_checker #(parameter DUPIDX = 1) (
   input wire        i_core_clk, i_rst_n, i_psel, i_penable, i_pwrite,
   input wire [31:0] i_paddr, i_pwdata,
   input wire        i_acc_valid, i_acc_read, i_acc_dst_dreg,
   input wire [2:0]  i_acc_ireg,
   input wire        o_pready, o_mem_valid, o_mem_read,
   input wire        o_dst_named_we, o_dst_comp_we, o_dual_pe_select
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   a_addr_follows: assert property (i_acc_valid |=> o_mem_valid)
      else $error("no address after request");
   a_no_stray: assert property (!i_acc_valid |=> !o_mem_valid)
      else $error("address without request");
   a_dir_follows: assert property
      (i_acc_valid |=> o_mem_read == $past(i_acc_read))
      else $error("direction wrong");
   a_store_single: assert property
      (i_acc_valid && !i_acc_read |=> !o_dst_named_we && !o_dst_comp_we)
      else $error("store wrote a register");
   a_ureg_single: assert property
      (i_acc_valid && !i_acc_dst_dreg |=> !o_dst_comp_we)
      else $error("universal load duplicated");
   a_dup_idx_only: assert property
      (i_acc_valid && i_acc_ireg != DUPIDX |=> !o_dst_comp_we)
      else $error("duplicate through wrong index");
   a_dup_pair: assert property
      (o_dst_comp_we |-> o_dst_named_we && o_mem_read && o_mem_valid)
      else $error("lone complement write");
   a_dual_mode: assert property (i_psel && i_penable && i_pwrite &&
      o_pready && i_paddr == 0 |=> o_dual_pe_select == $past(i_pwdata[3]))
      else $error("mode bit not stored");
   c_dup: cover property (o_dst_comp_we);
   c_store: cover property (i_acc_valid && !i_acc_read);
   c_dual_dup: cover property (o_dual_pe_select && o_dst_comp_we);
endmodule // cbag_checker
bind cbag_top cbag_checker #(.DUPIDX(DUPIDX)) i_chk (.*);

// file: cbag_defines.vh
// constants for the circular/broadcast address generator
// Summary of operation
// R1: reset clears the global circular-addressing enable bit.
// R2: zero length disables circular mode for that index; nonzero enables it.
// R3: the old index goes out on the address bus; update follows.
// R4: positive step: if sum reaches base plus length, subtract length.
// R5: negative step: if sum falls below base, add length.
// R6: base write loads paired index in same cycle; both readable.
// R7: index write leaves base alone; base write ignores the global enable.
// R8: with global enable clear, plain post-modify, base and length ignored.
// R9: wraparound only on post-modify; pre-modify gets no correction.
// R10: step may come from any modify register of the generator, or immediate.
// R11: software keeps length positive and below two to the 31st.
// R12: software keeps step magnitude below the buffer length.
// R13: byte-space accesses use scaled step and length in wrap math.
// R14: address-space wrap is not detected; such results are undefined.
// R15: overflow status only from each generator's last index register.
// R16: a wrap through that register sets a sticky overflow flag.
// R17: duplicate-load enable writes data to named and complement register.
// R18: duplicate loading applies only to memory reads, never stores.
// R19: only data register destinations duplicate; universal registers do not.
// R20: duplicate loading is the same in single and dual-data mode.
// R21: software should pad odd buffers to even length in dual-data mode.
// R22: sticky overflow flags stay set until software clears them.
`ifndef CBAG_DEFINES_VH
`define CBAG_DEFINES_VH
`define CBAG_ADDR_MODE      32'h0000_0000
`define CBAG_ADDR_STICKY    32'h0000_0004
`define CBAG_ADDR_STATUS    32'h0000_0008
`define CBAG_MODE_CIRC_BIT  0
`define CBAG_MODE_DUP1_BIT  1
`define CBAG_MODE_DUP2_BIT  2
`define CBAG_MODE_DUAL_BIT  3
`define CBAG_STKY_OVF1_BIT  0
`define CBAG_STKY_OVF2_BIT  1
`define CBAG_MODE_RESET     4'h0
`define CBAG_STKY_RESET     2'h0
`define CBAG_BYTE_SHIFT     2
`endif

// file: cbag_mem_model.sv
// data memory bus model: counts address cycles from the generator
`timescale 1ns/1ps
module cbag_mem_model (
   input  wire         i_clk,
   input  wire         i_valid,
   output logic [31:0] o_count
);
   initial o_count = 32'h0000_0000;
   always @(posedge i_clk) if (i_valid) o_count <= o_count + 1;
endmodule // cbag_mem_model

// file: cbag_top.v
// circular buffer address generation with sticky overflow and dup loads
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "cbag_defines.vh"

module cbag_top #(
   parameter NREG    = 8,
   parameter LAST    = 7,
   parameter DUPIDX  = 1
) (
   input  wire        i_core_clk,
   input  wire        i_rst_n,
   // apb slave
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [31:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   // register-file port to the dag registers
   input  wire        i_rf_we,
   input  wire        i_rf_gen,
   input  wire [1:0]  i_rf_kind,
   input  wire [2:0]  i_rf_num,
   input  wire [31:0] i_rf_wdata,
   input  wire        i_rf_rgen,
   input  wire [1:0]  i_rf_rkind,
   input  wire [2:0]  i_rf_rnum,
   output wire [31:0] o_rf_rdata,
   // access request from decode
   input  wire        i_acc_valid,
   input  wire        i_acc_gen,
   input  wire [2:0]  i_acc_ireg,
   input  wire [2:0]  i_acc_mreg,
   input  wire        i_acc_use_imm,
   input  wire [31:0] i_acc_imm,
   input  wire        i_acc_pre,
   input  wire        i_acc_byte,
   input  wire        i_acc_read,
   input  wire        i_acc_dst_dreg,
   // memory address and register destination controls
   output reg  [31:0] o_mem_addr,
   output reg         o_mem_valid,
   output reg         o_mem_read,
   output reg         o_dst_named_we,
   output reg         o_dst_comp_we,
   output wire        o_dual_pe_select
);

   localparam KIND_I = 2'd0;
   localparam KIND_M = 2'd1;
   localparam KIND_L = 2'd2;
   localparam KIND_B = 2'd3;

   // ==========================================================
   // register storage, index 0..7 gen1, 8..15 gen2
   // ==========================================================
   reg [31:0] idx_q [0:2*NREG-1];
   reg [31:0] mod_q [0:2*NREG-1];
   reg [31:0] len_q [0:2*NREG-1];
   reg [31:0] base_q [0:2*NREG-1];
   reg [3:0]  main_mode_reg_q;
   reg [1:0]  sticky_status_reg_q;

   wire circ_addr_global_en = main_mode_reg_q[`CBAG_MODE_CIRC_BIT];
   wire gen1_dup_load_en    = main_mode_reg_q[`CBAG_MODE_DUP1_BIT];
   wire gen2_dup_load_en    = main_mode_reg_q[`CBAG_MODE_DUP2_BIT];
   assign o_dual_pe_select  = main_mode_reg_q[`CBAG_MODE_DUAL_BIT];

   function [3:0] slot;
      input       gen;
      input [2:0] num;
      begin
         slot = {gen, num};
      end
   endfunction

   // ==========================================================
   // address arithmetic
   // ==========================================================
   wire [3:0]  a_slot = slot(i_acc_gen, i_acc_ireg);
   wire [31:0] i_old  = idx_q[a_slot];
   wire [31:0] b_val  = base_q[a_slot];
   wire [31:0] l_raw  = len_q[a_slot];
   wire [31:0] m_raw  = i_acc_use_imm ? i_acc_imm :
                        mod_q[slot(i_acc_gen, i_acc_mreg)]; // [R10]
   // byte space scales step and length before the wrap compare
   wire [31:0] m_val  = i_acc_byte ? (m_raw << `CBAG_BYTE_SHIFT) : m_raw;
   wire [31:0] l_val  = i_acc_byte ? (l_raw << `CBAG_BYTE_SHIFT) : l_raw;
   // [R13]
   wire [31:0] sum    = i_old + m_val; // [R14]
   wire [31:0] endp   = b_val + l_val;
   wire        m_neg  = m_val[31];
   wire        circ   = circ_addr_global_en && (l_raw != 32'h0000_0000)
                        && !i_acc_pre; // [R2] [R8] [R9]
   wire        wrap_hi = !m_neg && (sum >= endp); // [R4]
   wire        wrap_lo = m_neg && (sum < b_val); // [R5]
   wire        wrap    = circ && (wrap_hi || wrap_lo);
   reg  [31:0] i_new;

   always @* begin
      i_new = sum;
      if (circ && wrap_hi) begin
         i_new = sum - l_val; // [R4]
      end else if (circ && wrap_lo) begin
         i_new = sum + l_val; // [R5]
      end
   end

   // ==========================================================
   // apb slave
   // ==========================================================
   wire apb_wr = i_psel && i_penable && i_pwrite;
   wire hit_mode = (i_paddr == `CBAG_ADDR_MODE);
   wire hit_stky = (i_paddr == `CBAG_ADDR_STICKY);
   wire hit_stat = (i_paddr == `CBAG_ADDR_STATUS);
   wire mapped   = hit_mode || hit_stky || hit_stat;
   reg  [31:0] rdata;

   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !mapped;
   assign o_prdata  = rdata;

   always @* begin
      rdata = 32'h0000_0000;
      if (hit_mode) begin
         rdata = {28'h000_0000, main_mode_reg_q};
      end else if (hit_stky || hit_stat) begin
         rdata = {30'h0000_0000, sticky_status_reg_q};
      end
   end

   // ==========================================================
   // mode and sticky registers
   // ==========================================================
   wire ovf1 = i_acc_valid && wrap && !i_acc_gen &&
               (i_acc_ireg == LAST[2:0]); // [R15]
   wire ovf2 = i_acc_valid && wrap && i_acc_gen &&
               (i_acc_ireg == LAST[2:0]); // [R15]

   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         main_mode_reg_q     <= `CBAG_MODE_RESET; // [R1]
         sticky_status_reg_q <= `CBAG_STKY_RESET;
      end else begin
         if (apb_wr && hit_mode) begin
            main_mode_reg_q <= i_pwdata[3:0];
         end
         // write-one-to-clear; a new wrap wins over the clear
         if (apb_wr && hit_stky) begin
            sticky_status_reg_q <= (sticky_status_reg_q & ~i_pwdata[1:0])
                                   | {ovf2, ovf1}; // [R22] [R16]
         end else begin
            sticky_status_reg_q <= sticky_status_reg_q | {ovf2, ovf1};
            // [R16]
         end
      end
   end

   // ==========================================================
   // dag register file
   // ==========================================================
   wire [3:0] w_slot = slot(i_rf_gen, i_rf_num);
   integer k;

   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (k = 0; k < 2*NREG; k = k + 1) begin
            idx_q[k]  <= 32'h0000_0000;
            mod_q[k]  <= 32'h0000_0000;
            len_q[k]  <= 32'h0000_0000;
            base_q[k] <= 32'h0000_0000;
         end
      end else begin
         // post-modify update after address issue
         if (i_acc_valid && !i_acc_pre) begin
            idx_q[a_slot] <= i_new; // [R3]
         end
         // register write after update so software wins the same slot
         if (i_rf_we) begin
            case (i_rf_kind)
               KIND_I: idx_q[w_slot] <= i_rf_wdata; // [R7]
               KIND_M: mod_q[w_slot] <= i_rf_wdata;
               KIND_L: len_q[w_slot] <= i_rf_wdata;
               KIND_B: begin
                  base_q[w_slot] <= i_rf_wdata; // [R6]
                  idx_q[w_slot]  <= i_rf_wdata; // [R6] [R7]
               end
               default: ;
            endcase
         end
      end
   end

   // separately readable base and index
   reg [31:0] rf_rd;
   wire [3:0] r_slot = slot(i_rf_rgen, i_rf_rnum);
   always @* begin
      case (i_rf_rkind)
         KIND_I:  rf_rd = idx_q[r_slot];
         KIND_M:  rf_rd = mod_q[r_slot];
         KIND_L:  rf_rd = len_q[r_slot];
         KIND_B:  rf_rd = base_q[r_slot]; // [R6]
         default: rf_rd = 32'h0000_0000;
      endcase
   end
   assign o_rf_rdata = rf_rd;

   // ==========================================================
   // address bus and duplicate load
   // ==========================================================
   wire dup_idx = (i_acc_ireg == DUPIDX[2:0]) &&
                  (i_acc_gen ? gen2_dup_load_en : gen1_dup_load_en);
   // dual-pe select intentionally not part of this term
   wire dup = dup_idx && i_acc_read && i_acc_dst_dreg;
   // [R17] [R18] [R19] [R20]

   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_addr     <= 32'h0000_0000;
         o_mem_valid    <= 1'b0;
         o_mem_read     <= 1'b0;
         o_dst_named_we <= 1'b0;
         o_dst_comp_we  <= 1'b0;
      end else begin
         // pre-modify issues index plus step, post-modify the old index
         o_mem_addr     <= i_acc_pre ? sum : i_old; // [R3] [R9]
         o_mem_valid    <= i_acc_valid;
         o_mem_read     <= i_acc_valid && i_acc_read;
         o_dst_named_we <= i_acc_valid && i_acc_read;
         o_dst_comp_we  <= i_acc_valid && dup; // [R17]
      end
   end

endmodule // cbag_top

// file: testbench.sv
// self-checking bench: circular addressing, sticky status, dup loads
`timescale 1ns/1ps
module testbench;
logic i_core_clk=0, i_rst_n=0, i_psel=0, i_penable=0, i_pwrite=0;
logic i_rf_we=0, i_rf_gen=0, i_rf_rgen=0, i_acc_valid=0, i_acc_gen=0;
logic i_acc_use_imm=0, i_acc_pre=0, i_acc_byte=0, i_acc_read=0;
logic i_acc_dst_dreg=0, o_pready, o_pslverr, o_mem_valid, o_mem_read;
logic o_dst_named_we, o_dst_comp_we, o_dual_pe_select, se, ov, ui, p, b;
logic [1:0] i_rf_kind=0, i_rf_rkind=0;
logic [2:0] i_rf_num=0, i_rf_rnum=0, i_acc_ireg=0, i_acc_mreg=0, ir;
logic [31:0] i_paddr=0, i_pwdata=0, i_rf_wdata=0, i_acc_imm=0, o_prdata;
logic [31:0] o_rf_rdata, o_mem_addr, r, s, sc, sl, seed=22, mcnt, idx[8];
int err_count=0, n_checks=0, cyc=0, nacc=0;
// even length keeps a dual-data implicit transfer inside the buffer
localparam [31:0] B = 32'h0000_1000, L = 32'h0000_0010;
cbag_top i_dut (.*);
cbag_mem_model i_mem (.i_clk(i_core_clk), .i_valid(o_mem_valid),
   .o_count(mcnt));
initial forever #2 i_core_clk = ~i_core_clk;
// ==========================================
// shared tasks
task chk(input [31:0] got, exp);
   n_checks++;
   if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
   end
endtask
task end_of_test;
   $display("checks %0d mismatches %0d", n_checks, err_count);
   if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
   else $display("TEST FAILED");
   $finish;
endtask
function [31:0] rnd();
   seed = seed ^ (seed << 13);
   seed = seed ^ (seed >> 17);
   seed = seed ^ (seed << 5);
   rnd = seed;
endfunction
// zero length means no wrap at all
function [31:0] nxt(input [31:0] i, m, l);
   nxt = i + m;
   if (l != 0 && !m[31] && nxt >= B + l) nxt = nxt - l;
   if (l != 0 && m[31] && nxt < B) nxt = nxt + l;
endfunction
task apb(input w, input [31:0] a, d);
   @(posedge i_core_clk);
   {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
   @(posedge i_core_clk);
   i_penable <= 1;
   do @(posedge i_core_clk); while (o_pready !== 1'b1);
   r = o_prdata;
   se = o_pslverr;
   {i_psel, i_penable} <= 2'b00;
endtask
task rfw(input g, input [1:0] k, input [2:0] n, input [31:0] d);
   @(posedge i_core_clk);
   {i_rf_we, i_rf_gen, i_rf_kind, i_rf_num, i_rf_wdata} <= {1'b1, g, k, n, d};
   @(posedge i_core_clk);
   i_rf_we <= 0;
endtask
task rfr(input g, input [1:0] k, input [2:0] n);
   @(posedge i_core_clk);
   {i_rf_rgen, i_rf_rkind, i_rf_rnum} <= {g, k, n};
   #1 r = o_rf_rdata;
endtask
task acc(input g, input [2:0] i, m, input u, input [31:0] im,
         input pr, by, rd, dr);
   @(posedge i_core_clk);
   {i_acc_valid, i_acc_gen, i_acc_ireg, i_acc_mreg, i_acc_use_imm} <=
      {1'b1, g, i, m, u};
   {i_acc_imm, i_acc_pre, i_acc_byte, i_acc_read, i_acc_dst_dreg} <=
      {im, pr, by, rd, dr};
   @(posedge i_core_clk);
   i_acc_valid <= 0;
   nacc++;
   #1;
endtask
// ==========================================
// circular pass: index 7 wraps when the global enable k is set, index 2 has zero length
task pass(input g, k);
   apb(1, 0, {31'h0, k});
   rfw(g, 3, 7, B);
   rfw(g, 2, 7, L);
   rfw(g, 3, 2, B);
   idx[7] = B;
   idx[2] = B;
   ov = 0;
   repeat (16) begin
      s = rnd() % (L - 1) + 1;
      if (seed[3]) s = -s;
      {ui, p, b} = {seed[4], seed[5] & seed[6], seed[7]};
      ir = seed[9] ? 3'd7 : 3'd2;
      if (!ui) rfw(g, 1, 5, s);
      acc(g, ir, 5, ui, ui ? s : ~s, p, b, 1, 0);
      sc = b ? s << 2 : s;
      sl = (ir == 7 && k) ? (b ? L << 2 : L) : 0;
      chk(o_mem_addr, p ? idx[ir] + sc : idx[ir]);
      if (!p) begin
         r = nxt(idx[ir], sc, sl);
         ov = ov | (r != idx[ir] + sc);
         idx[ir] = r;
      end
      rfr(g, 0, ir);
      chk(r, idx[ir]);
   end
   apb(0, 8, 0);
   chk(r, ov ? 32'h1 << g : 0);
   apb(1, 4, 3);
   apb(0, 4, 0);
   chk(r, 0);
   $display("circular pass gen %0d enable %0d done", g, k);
endtask
always @(posedge i_core_clk) if (++cyc == 20000) begin
   err_count++;
   end_of_test;
end
initial begin
   repeat (6) @(posedge i_core_clk);
   i_rst_n <= 1;
   apb(0, 0, 0);
   chk(r, 0);
   apb(0, 32'h0000_0010, 0);
   chk({se, r[0]}, 2'b10);
   rfw(0, 3, 7, B);
   rfw(0, 0, 7, B + 4);
   rfr(0, 3, 7);
   chk(r, B);
   for (int k = 0; k < 4; k++) pass(k[0], k[1]);
   for (int m = 0; m < 4; m++) begin
      apb(1, 0, {28'h0, m[1], m[0], m[0], 1'b0});
      for (int c = 0; c < 16; c++) begin
         acc(c[3], c[2] ? 3'd1 : 3'd2, 0, 1, 0, 0, 0, c[1], c[0]);
         chk({o_dual_pe_select, o_mem_read, o_dst_named_we, o_dst_comp_we},
             {m[1], c[1], c[1], m[0] & c[2] & c[1] & c[0]});
      end
   end
   $display("duplicate load test done");
   // memory model counts the last address cycle one edge later
   @(posedge i_core_clk);
   #1;
   chk(mcnt, nacc);
   end_of_test;
end
endmodule // testbench
